// ==== inc/opamp_regs_pkg.sv ====
// constants and types for the amplifier routing register bank
// ==========================================================
package opamp_regs_pkg;
	// ==========================================================
	// register byte addresses
	localparam logic [3:0] amp1_status_addr = 4'h0;
	localparam logic [3:0] amp1_ctrl_addr = 4'h4;
	localparam logic [3:0] amp2_status_addr = 4'h8;
	localparam logic [3:0] amp2_ctrl_addr = 4'hC;
	localparam logic [3:0] amp2_gain_addr = 4'h0;
	localparam logic [4:0] amp2_gain_byte = 5'h10;
	// ==========================================================
	// bit positions
	localparam int status_bit = 7;
	localparam int comp_route_bit = 7;
	localparam int feedback_bit = 6;
	localparam int ref_hi = 5;
	localparam int ref_lo = 4;
	localparam int pos_pin_bit = 3;
	localparam int neg_pin_bit = 2;
	localparam int out_en_bit = 1;
	localparam int enable_bit = 0;
	localparam int cross_inv_bit = 7;
	localparam int cross_noninv_bit = 6;
	localparam int gain_en_bit = 3;
	localparam logic [7:0] gain_wmask = 8'hCF;
	// ==========================================================
	// reset values and response codes
	localparam logic [7:0] ctrl_reset = 8'h0C;
	localparam logic [7:0] gain_reset = 8'h00;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	// ==========================================================
	// reference selector codes
	typedef enum logic [1:0] {
		ref_none = 2'b00,
		ref_high = 2'b01,
		ref_mid = 2'b10,
		ref_low = 2'b11
	} ref_sel_t;
	// decoded switch drive for one amplifier
	typedef struct packed {
		logic feedback_sw;
		logic high_ref_sw;
		logic mid_ref_sw;
		logic low_ref_sw;
		logic pos_pin_sw;
		logic neg_pin_sw;
		logic comp_sw;
		logic out_en;
		logic amp_en;
	} amp_switch_t;
	// amp2 gain stage drive
	typedef struct packed {
		logic gain_on;
		logic [5:0] gain_value;
		logic cross_inv_sw;
		logic cross_noninv_sw;
	} gain_drive_t;
endpackage : opamp_regs_pkg

// ==== rtl/opamp_routing_control_regs.sv ====
// amplifier routing and gain register bank with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module opamp_routing_control_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic amp1_output_sample,
	input wire logic amp2_output_sample,
	output opamp_regs_pkg::amp_switch_t amp1_drive,
	output opamp_regs_pkg::amp_switch_t amp2_drive,
	output opamp_regs_pkg::gain_drive_t gain_drive
);
	// ==========================================================
	// register state
	logic [7:0] amp1_ctrl_r;
	logic [7:0] amp2_ctrl_r;
	logic [7:0] amp2_gain_r;
	logic [7:0] amp1_ctrl_nxt;
	logic [7:0] amp2_ctrl_nxt;
	logic [7:0] amp2_gain_nxt;
	logic [7:0] amp1_status_r;
	logic [7:0] amp2_status_r;

	// ==========================================================
	// write channel: address and data taken in either order
	logic aw_held_r;
	logic w_held_r;
	logic [4:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_fire;
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 5'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
			s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	logic wr_hit1;
	logic wr_hit2;
	logic wr_hitg;
	logic wr_mapped;
	logic wr_lane0;
	assign wr_lane0 = w_strb_r[0];
	assign wr_hit1 = wr_fire && wr_lane0 && aw_addr_r == {1'b0, opamp_regs_pkg::amp1_ctrl_addr};
	assign wr_hit2 = wr_fire && wr_lane0 && aw_addr_r == {1'b0, opamp_regs_pkg::amp2_ctrl_addr};
	assign wr_hitg = wr_fire && wr_lane0 && aw_addr_r == opamp_regs_pkg::amp2_gain_byte;
	assign wr_mapped = aw_addr_r[4:2] <= opamp_regs_pkg::amp2_gain_byte[4:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= opamp_regs_pkg::resp_okay;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? opamp_regs_pkg::resp_okay : opamp_regs_pkg::resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// next register values with hardware interlocks
	// the interlocks are applied after the write merge so they win
	always_comb begin
		amp1_ctrl_nxt = wr_hit1 ? w_data_r[7:0] : amp1_ctrl_r;
		amp2_ctrl_nxt = wr_hit2 ? w_data_r[7:0] : amp2_ctrl_r;
		amp2_gain_nxt = wr_hitg ? (w_data_r[7:0] & opamp_regs_pkg::gain_wmask) : amp2_gain_r;
		if (!amp1_ctrl_nxt[opamp_regs_pkg::enable_bit])
			amp1_ctrl_nxt[opamp_regs_pkg::feedback_bit] = 1'b0;
		if (amp1_ctrl_nxt[opamp_regs_pkg::pos_pin_bit])
			amp1_ctrl_nxt[opamp_regs_pkg::ref_hi:opamp_regs_pkg::ref_lo] = opamp_regs_pkg::ref_none;
		if (!amp2_ctrl_nxt[opamp_regs_pkg::enable_bit]) begin
			amp2_ctrl_nxt[opamp_regs_pkg::feedback_bit] = 1'b0;
			amp2_gain_nxt[opamp_regs_pkg::gain_en_bit] = 1'b0;
		end
		if (amp2_ctrl_nxt[opamp_regs_pkg::pos_pin_bit]) begin
			amp2_ctrl_nxt[opamp_regs_pkg::ref_hi:opamp_regs_pkg::ref_lo] = opamp_regs_pkg::ref_none;
			amp2_gain_nxt[opamp_regs_pkg::cross_noninv_bit] = 1'b0;
		end
		if (amp2_ctrl_nxt[opamp_regs_pkg::neg_pin_bit])
			amp2_gain_nxt[opamp_regs_pkg::cross_inv_bit] = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp1_ctrl_r <= opamp_regs_pkg::ctrl_reset;
			amp2_ctrl_r <= opamp_regs_pkg::ctrl_reset;
			amp2_gain_r <= opamp_regs_pkg::gain_reset;
		end else begin
			amp1_ctrl_r <= amp1_ctrl_nxt;
			amp2_ctrl_r <= amp2_ctrl_nxt;
			amp2_gain_r <= amp2_gain_nxt;
		end
	end

	// output samples; low bits read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp1_status_r <= 8'h00;
			amp2_status_r <= 8'h00;
		end else begin
			amp1_status_r <= {amp1_output_sample, 7'h00};
			amp2_status_r <= {amp2_output_sample, 7'h00};
		end
	end

	// ==========================================================
	// read channel
	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			{1'b0, opamp_regs_pkg::amp1_status_addr}: rd_byte = amp1_status_r;
			{1'b0, opamp_regs_pkg::amp1_ctrl_addr}: rd_byte = amp1_ctrl_r;
			{1'b0, opamp_regs_pkg::amp2_status_addr}: rd_byte = amp2_status_r;
			{1'b0, opamp_regs_pkg::amp2_ctrl_addr}: rd_byte = amp2_ctrl_r;
			opamp_regs_pkg::amp2_gain_byte: rd_byte = amp2_gain_r;
			default: begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= opamp_regs_pkg::resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_ok ? opamp_regs_pkg::resp_okay : opamp_regs_pkg::resp_slverr;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// switch drive decode, registered
	function automatic opamp_regs_pkg::amp_switch_t decode_amp(input logic [7:0] c);
		opamp_regs_pkg::amp_switch_t d;
		d.amp_en = c[opamp_regs_pkg::enable_bit];
		d.out_en = c[opamp_regs_pkg::out_en_bit];
		d.comp_sw = c[opamp_regs_pkg::comp_route_bit];
		d.feedback_sw = c[opamp_regs_pkg::feedback_bit] && c[opamp_regs_pkg::enable_bit];
		d.pos_pin_sw = c[opamp_regs_pkg::pos_pin_bit];
		d.neg_pin_sw = c[opamp_regs_pkg::neg_pin_bit];
		d.high_ref_sw = c[opamp_regs_pkg::ref_hi:opamp_regs_pkg::ref_lo] == opamp_regs_pkg::ref_high;
		d.mid_ref_sw = c[opamp_regs_pkg::ref_hi:opamp_regs_pkg::ref_lo] == opamp_regs_pkg::ref_mid;
		d.low_ref_sw = c[opamp_regs_pkg::ref_hi:opamp_regs_pkg::ref_lo] == opamp_regs_pkg::ref_low;
		return d;
	endfunction : decode_amp

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp1_drive <= '0;
			amp2_drive <= '0;
			gain_drive <= '0;
		end else begin
			amp1_drive <= decode_amp(amp1_ctrl_nxt);
			amp2_drive <= decode_amp(amp2_ctrl_nxt);
			gain_drive.gain_on <= amp2_gain_nxt[opamp_regs_pkg::gain_en_bit];
			// code 0 is unity, otherwise eight times the code
			gain_drive.gain_value <= (amp2_gain_nxt[2:0] == 3'h0) ? 6'h01
				: {amp2_gain_nxt[2:0], 3'h0};
			gain_drive.cross_inv_sw <= amp2_gain_nxt[opamp_regs_pkg::cross_inv_bit];
			gain_drive.cross_noninv_sw <= amp2_gain_nxt[opamp_regs_pkg::cross_noninv_bit];
		end
	end

	// ==========================================================
	// checks
	property p_amp1_fb;
		@(posedge aclk) disable iff (!aresetn)
		!amp1_ctrl_r[opamp_regs_pkg::enable_bit] |-> !amp1_ctrl_r[opamp_regs_pkg::feedback_bit];
	endproperty
	amp1_feedback_lock_a: assert property (p_amp1_fb) else $error("amp1 feedback set while off");
	amp1_ref_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		amp1_ctrl_r[opamp_regs_pkg::pos_pin_bit] |-> amp1_ctrl_r[5:4] == 2'b00)
		else $error("amp1 reference not cleared");
	amp2_disable_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!amp2_ctrl_r[0] |-> !amp2_ctrl_r[6] && !amp2_gain_r[3])
		else $error("amp2 disable did not clear bits");
	amp2_pos_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		amp2_ctrl_r[3] |-> amp2_ctrl_r[5:4] == 2'b00 && !amp2_gain_r[6])
		else $error("amp2 positive pin did not clear");
	amp2_neg_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		amp2_ctrl_r[2] |-> !amp2_gain_r[7]) else $error("cross route not cleared");
	gain_unused_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		amp2_gain_r[5:4] == 2'b00) else $error("unused gain bits set");
	comp_switch_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
		amp1_drive.comp_sw == amp1_ctrl_r[7]) else $error("comparator switch mismatch");
	fb_switch_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!amp1_ctrl_r[0] |-> !amp1_drive.feedback_sw) else $error("feedback switch closed");
	status_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 amp1_status_r[7] == $past(amp1_output_sample)) else $error("status not sampled");
	gain_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
		amp2_gain_r[2:0] != 3'h0 |-> gain_drive.gain_value == {amp2_gain_r[2:0], 3'h0})
		else $error("gain value wrong");
endmodule : opamp_routing_control_regs
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the amplifier routing register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, s1, s2;
	logic [4:0] awaddr, araddr, a;
	logic [31:0] wdata, rdata, rd, x;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [7:0] c1, c2, g;
	logic [4:0] ad [3] = '{5'h04, 5'h0C, 5'h10};
	opamp_regs_pkg::amp_switch_t d1, d2;
	opamp_regs_pkg::gain_drive_t gd;
	integer seed, err_count, check_count, i;
	opamp_routing_control_regs dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.amp1_output_sample(s1), .amp2_output_sample(s2),
		.amp1_drive(d1), .amp2_drive(d2), .gain_drive(gd));
	// ==========================================================
	// clock and watchdog
	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		repeat (40000) @(posedge aclk);
		err_count = err_count + 1;
		results;
	end
	// ==========================================================
	// checking and expectations
	task automatic results;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		check_count = check_count + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("MISMATCH %0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask : chk
	function automatic opamp_regs_pkg::amp_switch_t dec(input logic [7:0] v);
		dec = {v[6], v[5:4] == 2'h1, v[5:4] == 2'h2, v[5:4] == 2'h3, v[3], v[2], v[7], v[1], v[0]};
	endfunction : dec
	function automatic opamp_regs_pkg::gain_drive_t gdec(input logic [7:0] v);
		gdec = {v[3], (v[2:0] == 3'h0) ? 6'h01 : {v[2:0], 3'h0}, v[7], v[6]};
	endfunction : gdec
	// forced clears applied after the written value, as the block must
	task automatic model(input logic [4:0] aa, input logic [7:0] v);
		if (aa == 5'h04) begin
			v[6] = v[6] & v[0];
			if (v[3]) v[5:4] = 2'h0;
			c1 = v;
		end else if (aa == 5'h0C) begin
			v[6] = v[6] & v[0];
			if (v[3]) v[5:4] = 2'h0;
			c2 = v;
			if (!v[0]) g[3] = 1'h0;
			if (v[3]) g[6] = 1'h0;
			if (v[2]) g[7] = 1'h0;
		end else if (aa == 5'h10) begin
			v = v & 8'hCF;
			if (!c2[0]) v[3] = 1'h0;
			if (c2[3]) v[6] = 1'h0;
			if (c2[2]) v[7] = 1'h0;
			g = v;
		end
	endtask : model
	// ==========================================================
	// bus master: ready seen at the falling edge is still true at the next rising one
	task automatic wr(input logic [4:0] aa, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw, got;
		got = 1'h0;
		@(posedge aclk);
		awaddr <= aa;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!got) begin
			@(negedge aclk);
			ta = awvalid & (awready === 1'h1);
			tw = wvalid & (wready === 1'h1);
			got = (bvalid === 1'h1);
			rs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end
		bready <= 1'h0;
	endtask : wr
	task automatic rdt(input logic [4:0] aa);
		logic ta, got;
		got = 1'h0;
		@(posedge aclk);
		araddr <= aa;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (!got) begin
			@(negedge aclk);
			ta = arvalid & (arready === 1'h1);
			got = (rvalid === 1'h1);
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'h0;
		end
		rready <= 1'h0;
	endtask : rdt
	task automatic verify;
		rdt(5'h04);
		chk(rd, {24'h0, c1}, "amp1 ctrl");
		rdt(5'h0C);
		chk(rd, {24'h0, c2}, "amp2 ctrl");
		rdt(5'h10);
		chk(rd, {24'h0, g}, "gain reg");
		chk({23'h0, d1}, {23'h0, dec(c1)}, "amp1 drive");
		chk({23'h0, d2}, {23'h0, dec(c2)}, "amp2 drive");
		chk({23'h0, gd}, {23'h0, gdec(g)}, "gain drive");
	endtask : verify
	task automatic wrc(input logic [4:0] aa, input logic [31:0] d);
		wr(aa, d, 4'hF);
		chk({30'h0, rs}, 32'h0, "bresp");
		model(aa, d[7:0]);
		verify;
	endtask : wrc
	// ==========================================================
	// main sequence
	initial begin
		seed = 32'h20FF;
		err_count = 0;
		check_count = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, s1, s2} = 8'h00;
		{awaddr, araddr, wdata, wstrb} = 46'h0;
		{c1, c2, g} = 24'h0C0C00;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		verify;
		wrc(5'h04, 32'hFFFF_FFFF);
		wrc(5'h04, 32'h0000_0070);
		wrc(5'h0C, 32'h0000_0001);
		for (i = 0; i < 8; i = i + 1) wrc(5'h10, 32'h8 | i);
		wrc(5'h0C, 32'h0000_0042);
		wrc(5'h0C, 32'h0000_0001);
		wrc(5'h10, 32'h0000_00F0);
		wrc(5'h0C, 32'h0000_000D);
		wrc(5'h0C, 32'h0000_00A1);
		wr(5'h04, 32'h0000_00FF, 4'h0);
		verify;
		wr(5'h14, 32'h0000_00FF, 4'hF);
		chk({30'h0, rs}, 32'h2, "unmapped write");
		rdt(5'h18);
		chk({30'h0, rs}, 32'h2, "unmapped read");
		chk(rd, 32'h0, "unmapped data");
		verify;
		for (i = 0; i < 4; i = i + 1) begin
			s1 <= i[0];
			s2 <= i[1];
			repeat (3) @(posedge aclk);
			rdt(5'h00);
			chk(rd, {24'h0, i[0], 7'h0}, "amp1 status");
			rdt(5'h08);
			chk(rd, {24'h0, i[1], 7'h0}, "amp2 status");
		end
		for (i = 0; i < 200; i = i + 1) begin
			x = $random(seed);
			a = ad[x[9:8] % 2'h3];
			s1 <= x[16];
			s2 <= x[17];
			wrc(a, x);
		end
		// second reset in mid-run must restore both control registers and the gain register
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		{c1, c2, g} = 24'h0C0C00;
		verify;
		results;
	end
endmodule : tb_top
`default_nettype wire
